/* File: bench/standby_wakeup_source_control_properties.sv */
// checker for the standby wakeup block, bound to its top ports
// assumes one clock domain, pclk, with presetn active low
`timescale 1ns/1ps
`default_nettype none
module standby_wakeup_source_control_properties
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic standby,
   input wire logic high_freq_crystal_oscillator,
   input wire logic adc_data_ready,
   input wire logic random_ready,
   input wire logic wakeup_request,
   input wire logic miscellaneous_interrupt,
   input wire logic pin_wakeup_interrupt
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // any of the three misc events, and a write access
   wire logic ev = high_freq_crystal_oscillator | adc_data_ready | random_ready;
   wire logic wr_acc = psel & penable & pwrite;
   ////////////////////////////////////////////////////////////////
   property p_ready; pready == (psel && penable && clk_en); endproperty
   property p_err; pslverr |-> pready && (pwrite || prdata == 32'h0); endproperty
   property p_idle; clk_en && !standby |=> !wakeup_request; endproperty
   property p_wake; $rose(wakeup_request) |-> $past(standby); endproperty
   property p_mset; clk_en && ev |=> miscellaneous_interrupt; endproperty
   property p_mhold; miscellaneous_interrupt && !wr_acc |=> miscellaneous_interrupt; endproperty
   property p_mcause; $rose(miscellaneous_interrupt) |-> $past(ev); endproperty
   property p_freeze;
      !clk_en |=> $stable(wakeup_request) && $stable(pin_wakeup_interrupt) && $stable(miscellaneous_interrupt);
   endproperty
   a_ready: assert property (p_ready) else $error("pready mismatch");
   a_err: assert property (p_err) else $error("error response bad");
   a_idle: assert property (p_idle) else $error("wake outside standby");
   a_wake: assert property (p_wake) else $error("wake without standby");
   a_mset: assert property (p_mset) else $error("misc not set");
   a_mhold: assert property (p_mhold) else $error("misc lost");
   a_mcause: assert property (p_mcause) else $error("misc without event");
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");
   c_wake: cover property ($rose(wakeup_request));
   c_err: cover property (pslverr);
   c_pin: cover property ($rose(pin_wakeup_interrupt));
endmodule
bind standby_wakeup_source_control standby_wakeup_source_control_properties u_props
(
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .standby(standby),
   .high_freq_crystal_oscillator(high_freq_crystal_oscillator), .adc_data_ready(adc_data_ready),
   .random_ready(random_ready), .wakeup_request(wakeup_request),
   .miscellaneous_interrupt(miscellaneous_interrupt), .pin_wakeup_interrupt(pin_wakeup_interrupt)
);
`default_nettype wire

/* File: bench/standby_wakeup_source_control_tb.sv */
// self-checking bench for the standby wakeup block, 48-pin variant
// assumes the source model drives sources and pins; apb from tasks here
`timescale 1ns/1ps
`default_nettype none
module standby_wakeup_source_control_tb;
   import wakeup_pkg::*;
   localparam logic [15:0] IENB = 16'h4351; // ien bit per source
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = 32'h0;
   logic standby = 1'b0;
   logic [3:0] src_on = 4'h0;
   logic [31:0] pin_lvl = 32'h0;
   logic csn_lvl = 1'b1;
   logic [31:0] prdata, rq, pins;
   logic [2:0] mev;
   logic pready, pslverr, wakeup_request, miscellaneous_interrupt, pin_wakeup_interrupt, irq;
   logic re, radio, tick, csn_n;
   int failures = 0;
   int num_checks = 0;
   int cyc = 0;
   always #2 pclk = ~pclk;
   standby_wakeup_source_control #(.VARIANT(PKG_48)) DUT
   (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .standby(standby), .radio_interrupt(radio), .real_time_counter(tick),
      .high_freq_crystal_oscillator(mev[0]), .adc_data_ready(mev[1]), .random_ready(mev[2]),
      .port0(pins[7:0]), .port1(pins[15:8]), .port2(pins[23:16]), .port3(pins[31:24]),
      .spi_slave_chip_select_n(csn_n), .wakeup_request(wakeup_request),
      .miscellaneous_interrupt(miscellaneous_interrupt), .pin_wakeup_interrupt(pin_wakeup_interrupt),
      .irq(irq)
   );
   wakeup_source_model u_model
   (
      .pclk(pclk), .src_on(src_on), .pin_lvl(pin_lvl), .csn_lvl(csn_lvl), .radio(radio),
      .tick(tick), .mev(mev), .pins(pins), .csn_n(csn_n)
   );
   ////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (failures == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one apb transfer; held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         failures++;
         tally_and_finish();
      end
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      apb(1'b1, i, {24'h0, d});
   endtask
   task automatic rd(input logic [7:0] i, input logic [31:0] x);
      apb(1'b0, i, 32'h0);
      check("rdata", rq, x);
   endtask
   task automatic pchk(input logic e);
      tk(8);
      check("pin_irq", {31'h0, pin_wakeup_interrupt}, {31'h0, e});
   endtask
   ////////////////////////////////////////////////////////////////
   // reset values, readback, unmapped access
   task automatic t_regs();
      rd(IDX_POLICY, 32'h0);
      rd(IDX_PIN_EN_HIGH, 32'h0);
      rd(IDX_PIN_EN_LOW, 32'h0);
      wr(IDX_POLICY, 8'h5a);
      rd(IDX_POLICY, 32'h5a);
      apb(1'b0, 8'h20, 32'h0);
      check("slverr", {31'h0, re}, 32'h1);
      check("errdata", rq, 32'h0);
   endtask
   // every source under every code, with and without its enable
   task automatic t_policy();
      int s, c, k;
      wr(IDX_PIN_EN_LOW, 8'h01);
      standby <= 1'b1;
      for (s = 0; s < 4; s++)
         for (c = 0; c < 4; c++)
            for (k = 0; k < 2; k++)
            begin
               wr(IDX_POLICY, 8'(c << (6 - 2 * s)));
               wr(IDX_INT_EN_ONE, 8'(k << IENB[4*s+:4]));
               src_on <= 4'(1 << s);
               tk(8);
               check("wake", {31'h0, wakeup_request}, {31'h0, (c == 0 && k == 1) || c == 2});
               src_on <= 4'h0;
               wr(IDX_IRQ_CLEAR, 8'h07);
               tk(8);
            end
      // always-wake policy has no effect outside standby
      standby <= 1'b0;
      wr(IDX_POLICY, 8'haa);
      src_on <= 4'h1;
      tk(8);
      check("wake", {31'h0, wakeup_request}, 32'h0);
      wr(IDX_IRQ_CLEAR, 8'h07);
      standby <= 1'b1;
      tk(3);
      check("wake", {31'h0, wakeup_request}, 32'h1);
      rd(IDX_IRQ_STATUS, 32'h4);
      clk_en <= 1'b0;
      tk(3);
      clk_en <= 1'b1;
      src_on <= 4'h0;
      standby <= 1'b0;
      tk(3);
   endtask
   // pin mapping, polarity subset, chip select source
   task automatic t_pins();
      wr(IDX_POLICY, 8'h00);
      wr(IDX_PIN_EN_LOW, 8'h00);
      pin_lvl <= 32'h0000_8000;
      pchk(1'b0);
      wr(IDX_PIN_EN_HIGH, 8'h80);
      pchk(1'b1);
      rd(IDX_LIVE, 32'h0000_8000);
      wr(IDX_PIN_EN_HIGH, 8'h40);
      pin_lvl <= 32'h4000_0000;
      pchk(1'b1);
      pin_lvl <= 32'h0;
      wr(IDX_PIN_EN_HIGH, 8'h00);
      wr(IDX_PIN_EN_LOW, 8'hc0);
      pchk(1'b0);
      wr(IDX_OP_MODE, 8'h04);
      pchk(1'b1);
      wr(IDX_PIN_EN_LOW, 8'h80);
      pchk(1'b0);
      wr(IDX_OP_MODE, 8'h00);
      wr(IDX_PIN_EN_LOW, 8'h00);
      csn_lvl <= 1'b0;
      pchk(1'b0);
      wr(IDX_SPI_SLAVE, 8'h01);
      pchk(1'b1);
      csn_lvl <= 1'b1;
      pchk(1'b0);
   endtask
   // misc status raises, masks and clears the interrupt
   task automatic t_irq();
      wr(IDX_IRQ_CLEAR, 8'h07);
      wr(IDX_IRQ_ENABLE, 8'h01);
      src_on <= 4'h8;
      tk(4);
      check("misc", {31'h0, miscellaneous_interrupt}, 32'h1);
      check("irq", {31'h0, irq}, 32'h1);
      rd(IDX_IRQ_STATUS, 32'h1);
      wr(IDX_IRQ_ENABLE, 8'h00);
      check("irq", {31'h0, irq}, 32'h0);
      wr(IDX_IRQ_ENABLE, 8'h01);
      wr(IDX_IRQ_CLEAR, 8'h01);
      check("irq", {31'h0, irq}, 32'h0);
      check("misc", {31'h0, miscellaneous_interrupt}, 32'h0);
      src_on <= 4'h0;
   endtask
   ////////////////////////////////////////////////////////////////
   // hang guard
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         tally_and_finish();
      end
   end
   initial
   begin
      tk(5);
      presetn <= 1'b1;
      t_regs();
      t_policy();
      t_pins();
      t_irq();
      tally_and_finish();
   end
endmodule
`default_nettype wire

/* File: bench/wakeup_source_model.sv */
// far side model: interrupt sources, port pins and spi chip select
// assumes the bench gives levels on pclk edges; sources change on pclk
`timescale 1ns/1ps
`default_nettype none
module wakeup_source_model
(
   input wire logic pclk,
   input wire logic [3:0] src_on,
   input wire logic [31:0] pin_lvl,
   input wire logic csn_lvl,
   output logic radio,
   output logic tick,
   output logic [2:0] mev,
   output logic [31:0] pins,
   output logic csn_n
);
   logic prev_q; // last misc request level
   logic [2:0] sel_q; // which misc event fires next
   initial
   begin
      {radio, tick, mev, pins, prev_q} = '0;
      csn_n = 1'b1;
      sel_q = 3'h1;
   end
   // sources follow the bench one edge later; src_on[2] drives pin 2.0
   always @(posedge pclk)
   begin
      radio <= src_on[0];
      tick <= src_on[1];
      pins <= pin_lvl | {15'h0, src_on[2], 16'h0};
      csn_n <= csn_lvl;
      // one event pulse per request, rotating crystal, adc, random
      mev <= (src_on[3] && !prev_q) ? sel_q : 3'h0;
      if (src_on[3] && !prev_q)
         sel_q <= {sel_q[1:0], sel_q[2]};
      prev_q <= src_on[3];
   end
endmodule
`default_nettype wire

/* File: core/pin_wakeup_if.sv */
// carrier between the register core and the pin mapper
// assumes both ends run on the same clock; the mapper is combinational
`timescale 1ns/1ps
`default_nettype none
interface pin_wakeup_if;
   import wakeup_pkg::*;
   logic [PIN_EN_W-1:0] enable; // per-bit wakeup enables
   logic low_polarity; // selectable pins active low
   logic [PIN_W-1:0] pins; // synchronised port pins
   logic [PIN_EN_W-1:0] hits; // enabled, active pins
   modport core (output enable, output low_polarity, output pins, input hits);
   modport mapper (input enable, input low_polarity, input pins, output hits);
endinterface
`default_nettype wire

/* File: core/pin_wakeup_map.sv */
// maps the sixteen enable bits onto port pins for one package variant
// assumes pins are already synchronised to the block clock
`timescale 1ns/1ps
`default_nettype none
module pin_wakeup_map
   import wakeup_pkg::*;
#(
   parameter pkg_variant_t VARIANT = PKG_48
)
(
   pin_wakeup_if.mapper bus
);

   ////////////////////////////////////////////////////////////////////////
   // per-variant masks
   wire logic [15:0] valid_mask; // bits that reach a pin
   wire logic [15:0] polsel_mask; // bits with selectable polarity
   assign valid_mask = (VARIANT == PKG_48) ? VALID_48 : (VARIANT == PKG_32) ? VALID_32 : VALID_24;
   assign polsel_mask = (VARIANT == PKG_48) ? POLSEL_48 : (VARIANT == PKG_32) ? POLSEL_32 : POLSEL_24;

   ////////////////////////////////////////////////////////////////////////
   // one wakeup term per enable bit
   genvar i;
   generate
      for (i = 0; i < PIN_EN_W; i++)
      begin : g_bit
         wire logic pin; // pin behind this bit
         wire logic active; // pin after polarity
         if (VARIANT == PKG_48)
         begin : g_48
            // low bits on port 2, high on port 3, top bit on port 1 pin 7
            if (i < HIGH_BASE)
            begin : g_lo
               assign pin = bus.pins[PORT2_BASE + i];
            end
            else if (i < TOP_BIT)
            begin : g_hi
               assign pin = bus.pins[PORT3_BASE + i - HIGH_BASE];
            end
            else
            begin : g_top
               assign pin = bus.pins[PORT1_BASE + 7];
            end
         end
         else
         begin : g_small
            // low bits on port 0, high bits on port 1
            assign pin = bus.pins[i];
         end
         // selectable pins go active low when asked, the rest stay high
         assign active = pin ^ (polsel_mask[i] & bus.low_polarity);
         assign bus.hits[i] = bus.enable[i] & valid_mask[i] & active;
      end
   endgenerate

endmodule
`default_nettype wire

/* File: core/standby_wakeup_source_control.sv */
// standby wakeup source control: apb registers, source policy, pin wakeup
// assumes pins and chip select are asynchronous; interrupt sources, standby
// and clock enable come from logic on pclk
//
// Behaviour
// - policy applies only while in standby
// - radio field 7:6, enabled/always/ignore
// - tick field 5:4, enabled/always/ignore
// - pin wakeup field 3:2, enabled/always/ignore
// - miscellaneous field 1:0, enabled/always/ignore
// - miscellaneous from crystal, adc or random
// - enable bits gate pins, reset zero
// - 48-pin mapping on ports 1, 2, 3
// - 32-pin mapping on ports 0, 1; 24-pin mapping on port 0 pins 0 to 6 only
// - only listed pins have selectable polarity
// - mode bit 2 selects active-low subset
// - spi chip select wakes, active low
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module standby_wakeup_source_control
   import wakeup_pkg::*;
#(
   parameter pkg_variant_t VARIANT = PKG_48
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic standby,
   input wire logic radio_interrupt,
   input wire logic real_time_counter,
   input wire logic high_freq_crystal_oscillator,
   input wire logic adc_data_ready,
   input wire logic random_ready,
   input wire logic [7:0] port0,
   input wire logic [7:0] port1,
   input wire logic [7:0] port2,
   input wire logic [7:0] port3,
   input wire logic spi_slave_chip_select_n,
   output logic wakeup_request,
   output logic miscellaneous_interrupt,
   output logic pin_wakeup_interrupt,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] policy_q; // wakeup_source_policy
   logic [7:0] pin_en_high_q; // pin_wakeup_enable_high
   logic [7:0] pin_en_low_q; // pin_wakeup_enable_low
   logic [7:0] op_mode_q; // operational_mode_control
   logic [7:0] spi_ctl_q; // spi_slave_control
   logic [7:0] ien_q; // interrupt_enable_group_one
   logic [ST_W-1:0] status_q; // sticky events
   logic [ST_W-1:0] status_d; // next sticky events
   logic [ST_W-1:0] irq_en_q; // interrupt output enables
   logic [31:0] prdata_q; // read data, loaded in setup
   logic wake_q; // registered wakeup request
   logic pin_irq_q; // registered pin wakeup level

   // two-flop synchroniser for the pins and chip select
   logic [PIN_W:0] sync1_q; // first stage, read only by second
   logic [PIN_W:0] sync2_q; // second stage, safe to use

   ////////////////////////////////////////////////////////////////////////
   // apb address decode
   wire logic [7:0] idx; // register index
   wire logic addr_low_ok; // low and top address bits zero
   wire logic setup_ph; // first cycle of a transfer
   wire logic access_ph; // completing cycle
   wire logic wr_en; // write takes effect now
   wire logic sel_policy;
   wire logic sel_en_high;
   wire logic sel_en_low;
   wire logic sel_op_mode;
   wire logic sel_spi;
   wire logic sel_ien;
   wire logic sel_status;
   wire logic sel_clear;
   wire logic sel_irq_en;
   wire logic sel_live;
   wire logic mapped; // address hits a register
   logic [31:0] rd_mux; // selected read value

   assign idx = paddr[IDX_LSB +: 8];
   assign addr_low_ok = (paddr[IDX_LSB-1:0] == 2'h0) && (paddr[ADDR_W-1:IDX_LSB+8] == 2'h0);
   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable & clk_en;
   assign sel_policy = addr_low_ok && (idx == IDX_POLICY);
   assign sel_en_high = addr_low_ok && (idx == IDX_PIN_EN_HIGH);
   assign sel_en_low = addr_low_ok && (idx == IDX_PIN_EN_LOW);
   assign sel_op_mode = addr_low_ok && (idx == IDX_OP_MODE);
   assign sel_spi = addr_low_ok && (idx == IDX_SPI_SLAVE);
   assign sel_ien = addr_low_ok && (idx == IDX_INT_EN_ONE);
   assign sel_status = addr_low_ok && (idx == IDX_IRQ_STATUS);
   assign sel_clear = addr_low_ok && (idx == IDX_IRQ_CLEAR);
   assign sel_irq_en = addr_low_ok && (idx == IDX_IRQ_ENABLE);
   assign sel_live = addr_low_ok && (idx == IDX_LIVE);
   assign mapped = sel_policy | sel_en_high | sel_en_low | sel_op_mode | sel_spi | sel_ien
      | sel_status | sel_clear | sel_irq_en | sel_live;
   assign wr_en = access_ph & pwrite & mapped;

   // zero-wait slave; frozen while clock enable is low
   assign pready = access_ph;
   assign pslverr = access_ph & ~mapped;
   assign prdata = prdata_q;

   ////////////////////////////////////////////////////////////////////////
   // pin mapping
   pin_wakeup_if pbus();
   wire logic spi_en; // chip select counts as a wakeup pin
   wire logic csn_hit; // chip select low while enabled
   wire logic pin_event; // any enabled pin active

   assign pbus.enable = {pin_en_high_q, pin_en_low_q};
   assign pbus.low_polarity = op_mode_q[OPM_LOW_POL_BIT];
   assign pbus.pins = sync2_q[PIN_W-1:0];
   assign spi_en = spi_ctl_q[SPI_EN_BIT];
   assign csn_hit = spi_en & ~sync2_q[PIN_W];
   assign pin_event = (|pbus.hits) | csn_hit;

   pin_wakeup_map #(
      .VARIANT(VARIANT)
   ) u_map (
      .bus(pbus)
   );

   ////////////////////////////////////////////////////////////////////////
   // source policy
   wire logic misc_event; // any miscellaneous cause
   wire logic wake_radio;
   wire logic wake_tick;
   wire logic wake_pin;
   wire logic wake_misc;
   wire logic wake_any; // qualified source in standby

   assign misc_event = high_freq_crystal_oscillator | adc_data_ready | random_ready;
   assign wake_radio = policy_wake(policy_q[POL_RADIO_LSB +: 2], ien_q[IEN_RADIO_BIT], radio_interrupt);
   assign wake_tick = policy_wake(policy_q[POL_TICK_LSB +: 2], ien_q[IEN_TICK_BIT], real_time_counter);
   assign wake_pin = policy_wake(policy_q[POL_PIN_LSB +: 2], ien_q[IEN_PIN_BIT], pin_irq_q);
   assign wake_misc = policy_wake(policy_q[POL_MISC_LSB +: 2], ien_q[IEN_MISC_BIT],
      status_q[ST_MISC]);
   assign wake_any = standby & (wake_radio | wake_tick | wake_pin | wake_misc);

   assign wakeup_request = wake_q;
   assign miscellaneous_interrupt = status_q[ST_MISC];
   assign pin_wakeup_interrupt = pin_irq_q;
   assign irq = |(status_q & irq_en_q);

   ////////////////////////////////////////////////////////////////////////
   // sticky status: a set in the clearing cycle wins
   wire logic [ST_W-1:0] st_set; // events this cycle
   wire logic [ST_W-1:0] st_clr; // software clears this cycle
   assign st_set = {wake_any, pin_event, misc_event};
   assign st_clr = (wr_en & sel_clear) ? pwdata[ST_W-1:0] : {ST_W{1'b0}};

   always_comb
   begin
      status_d = (status_q & ~st_clr) | st_set;
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (sel_policy)
      begin
         rd_mux[7:0] = policy_q;
      end
      else if (sel_en_high)
      begin
         rd_mux[7:0] = pin_en_high_q;
      end
      else if (sel_en_low)
      begin
         rd_mux[7:0] = pin_en_low_q;
      end
      else if (sel_op_mode)
      begin
         rd_mux[7:0] = op_mode_q;
      end
      else if (sel_spi)
      begin
         rd_mux[7:0] = spi_ctl_q;
      end
      else if (sel_ien)
      begin
         rd_mux[7:0] = ien_q;
      end
      else if (sel_status)
      begin
         rd_mux[ST_W-1:0] = status_q;
      end
      else if (sel_irq_en)
      begin
         rd_mux[ST_W-1:0] = irq_en_q;
      end
      else if (sel_live)
      begin
         // live pin hits, chip select hit, standby, request
         rd_mux[PIN_EN_W-1:0] = pbus.hits;
         rd_mux[PIN_EN_W] = csn_hit;
         rd_mux[PIN_EN_W+1] = standby;
         rd_mux[PIN_EN_W+2] = wake_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // synchroniser for asynchronous pins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else if (clk_en)
      begin
         sync1_q <= {spi_slave_chip_select_n, port3, port2, port1, port0};
         sync2_q <= sync1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         policy_q <= REG_RESET;
         pin_en_high_q <= REG_RESET;
         pin_en_low_q <= REG_RESET;
         op_mode_q <= REG_RESET;
         spi_ctl_q <= REG_RESET;
         ien_q <= REG_RESET;
         irq_en_q <= '0;
      end
      else if (wr_en)
      begin
         if (sel_policy)
         begin
            policy_q <= pwdata[7:0];
         end
         if (sel_en_high)
         begin
            pin_en_high_q <= pwdata[7:0];
         end
         if (sel_en_low)
         begin
            pin_en_low_q <= pwdata[7:0];
         end
         if (sel_op_mode)
         begin
            op_mode_q <= pwdata[7:0];
         end
         if (sel_spi)
         begin
            spi_ctl_q <= pwdata[7:0];
         end
         if (sel_ien)
         begin
            ien_q <= pwdata[7:0];
         end
         if (sel_irq_en)
         begin
            irq_en_q <= pwdata[ST_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status, wakeup and read data
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status_q <= '0;
         wake_q <= 1'b0;
         pin_irq_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         status_q <= status_d;
         wake_q <= wake_any;
         pin_irq_q <= pin_event;
         if (setup_ph)
         begin
            prdata_q <= rd_mux;
         end
      end
   end

endmodule
`default_nettype wire

/* File: core/wakeup_pkg.sv */
// constants, field layouts and helpers for the standby wakeup block
// assumes an apb register bus with 32-bit data and word-aligned registers
package wakeup_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_POLICY = 8'ha5; // wakeup_source_policy
   localparam logic [7:0] IDX_PIN_EN_HIGH = 8'hce; // pin_wakeup_enable_high
   localparam logic [7:0] IDX_PIN_EN_LOW = 8'hcf; // pin_wakeup_enable_low
   localparam logic [7:0] IDX_OP_MODE = 8'hae; // operational_mode_control
   localparam logic [7:0] IDX_SPI_SLAVE = 8'h10; // spi_slave_control
   localparam logic [7:0] IDX_INT_EN_ONE = 8'h11; // interrupt_enable_group_one
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h12; // sticky event status, read only
   localparam logic [7:0] IDX_IRQ_CLEAR = 8'h13; // write one to clear, write only
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'h14; // interrupt output enables
   localparam logic [7:0] IDX_LIVE = 8'h15; // live wakeup state, read only

   localparam int ADDR_W = 12; // apb address width
   localparam int IDX_LSB = 2; // word aligned
   localparam logic [7:0] REG_RESET = 8'h00; // every register resets to zero

   // policy field positions
   localparam int POL_RADIO_LSB = 6;
   localparam int POL_TICK_LSB = 4;
   localparam int POL_PIN_LSB = 2;
   localparam int POL_MISC_LSB = 0;

   // policy codes
   localparam logic [1:0] POLICY_IF_ENABLED = 2'h0;
   localparam logic [1:0] POLICY_ALWAYS = 2'h2;

   // interrupt enable group one bit positions
   localparam int IEN_RADIO_BIT = 1;
   localparam int IEN_PIN_BIT = 3;
   localparam int IEN_MISC_BIT = 4;
   localparam int IEN_TICK_BIT = 5;

   localparam int OPM_LOW_POL_BIT = 2; // subset of pins active low
   localparam int SPI_EN_BIT = 0; // spi slave enable

   // sticky status layout
   localparam int ST_MISC = 0; // miscellaneous interrupt
   localparam int ST_PIN = 1; // pin wakeup interrupt
   localparam int ST_WAKE = 2; // wakeup request raised
   localparam int ST_W = 3;

   localparam int PIN_EN_W = 16; // two eight-bit enable registers
   localparam int PIN_W = 32; // four eight-bit ports

   // package variants
   typedef enum logic [2:0]
   {
      PKG_48 = 3'h1,
      PKG_32 = 3'h2,
      PKG_24 = 3'h4
   } pkg_variant_t;

   // enable bits that map to a pin, per variant
   localparam logic [15:0] VALID_48 = 16'hffff;
   localparam logic [15:0] VALID_32 = 16'h7fff;
   localparam logic [15:0] VALID_24 = 16'h007f;
   // enable bits whose pin has selectable polarity
   localparam logic [15:0] POLSEL_48 = 16'h0044;
   localparam logic [15:0] POLSEL_32 = 16'h1440; // port 1 pins 4 and 2, port 0 pin 6
   localparam logic [15:0] POLSEL_24 = 16'h0040;
   // flat pin vector offsets of each port
   localparam int PORT1_BASE = 8;
   localparam int PORT2_BASE = 16;
   localparam int PORT3_BASE = 24;
   localparam int HIGH_BASE = 8; // first bit of the high enable register
   localparam int TOP_BIT = 15; // high register bit 7

   // one source under its two-bit policy
   function automatic logic policy_wake(input logic [1:0] policy, input logic ien, input logic irq);
      logic w;
      w = 1'b0;
      if (policy == POLICY_IF_ENABLED)
      begin
         w = irq & ien;
      end
      else if (policy == POLICY_ALWAYS)
      begin
         w = irq;
      end
      return w;
   endfunction

endpackage
